//--- dv/par_adc_model.sv
// converter sequencer model: start pulse, busy time, finish with data
// assumes commands from the bench on the same clock
`timescale 1ns/1ps
module par_adc_model
  import par_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] port_i,
  input wire par_kind_t kind_i,
  input wire logic [RES_W-1:0] data_i,
  input wire logic [3:0] dly_i,
  output par_adc_evt_t evt_o,
  output logic busy_o
);
  logic [3:0] cnt_q; // cycles left
  logic [RES_W-1:0] dat_q; // held result
  initial
  begin
    evt_o = '0;
    busy_o = 1'b0;
  end
  // data line toggles outside finish, so the last word and its complement alternate
  always @(posedge clk_i)
  begin
    evt_o.start <= 1'b0;
    evt_o.finish <= 1'b0;
    evt_o.data <= ~evt_o.data;
    if (go_i && !busy_o)
    begin
      busy_o <= 1'b1;
      cnt_q <= dly_i;
      evt_o.start <= 1'b1;
      evt_o.port <= port_i;
      evt_o.kind <= kind_i;
      dat_q <= data_i;
    end
    else if (busy_o && cnt_q == 4'h0)
    begin
      busy_o <= 1'b0;
      evt_o.finish <= 1'b1;
      evt_o.data <= dat_q;
    end
    else if (busy_o)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule // par_adc_model

//--- dv/par_props.sv
// checker for the result bank: bus timing, read values, irq
// assumes it is bound to par_top, one clock domain
`timescale 1ns/1ps
module par_props
  import par_pkg::*;
(
  // clock, reset, events
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire par_adc_evt_t adc_evt_i,
  // bus and irq
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rq; // any request
  logic res; // result select codes 8..D
  logic ack; // read answered
  assign rq = avs_read_i | avs_write_i;
  assign res = !avs_address_i[8] && avs_address_i[5:2] >= 4'h8
    && avs_address_i[5:2] <= 4'hD;
  assign ack = avs_read_i && !avs_waitrequest_o;
  chk_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  chk_wait_lat: assert property ($rose(rq) |=>
    avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("answer latency wrong");
  chk_no_spont: assert property (!avs_waitrequest_o |-> rq && $past(rq, 2))
    else $error("answer without request");
  chk_rd_hold: assert property (avs_waitrequest_o && $past(avs_waitrequest_o)
    |-> $stable(avs_readdata_o))
    else $error("read data moved");
  chk_rd_unmap: assert property (ack && !avs_address_i[8] && !res
    |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_rd_byte: assert property (ack && res
    |-> avs_readdata_o[31:8] == 24'h0)
    else $error("result read wider than a byte");
  chk_irq_rise: assert property ($rose(irq_o)
    |-> $past(adc_evt_i.finish) || $past(avs_write_i))
    else $error("irq rose without cause");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(avs_write_i, 2))
    else $error("irq fell without write");
  cov_read: cover property (ack);
  cov_write: cover property (avs_write_i && !avs_waitrequest_o);
  cov_irq: cover property ($rose(irq_o));
endmodule // par_props

//--- dv/par_top_tb_top.sv
// self-checking bench for the port result bank
// assumes par_top and the sequencer model on one 10 MHz clock
`timescale 1ns/1ps
module par_top_tb_top
  import par_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rd = 1'b0, wr = 1'b0, go = 1'b0, wreq, irq, busy;
  logic [8:0] addr = 9'h0;
  logic [31:0] wdat = 32'h0, rdat, seed = 32'h129B, r;
  logic [3:0] be = 4'hF, dly = 4'h5;
  logic [1:0] port = 2'h0;
  logic [14:0] data = 15'h0, old [12];
  logic seen [12];
  par_kind_t kind = KIND_VOLT;
  par_adc_evt_t evt;
  int error_cnt = 0, compares = 0;
  always #50 clk_i = ~clk_i;
  par_adc_model par_adc_model_inst (.clk_i(clk_i), .go_i(go),
    .port_i(port), .kind_i(kind), .data_i(data), .dly_i(dly),
    .evt_o(evt), .busy_o(busy));
  par_top par_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .adc_evt_i(evt), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // byte address of result i (port*3+kind), upper byte if h
  function automatic logic [8:0] ra(int i, int h);
    return {1'b0, 2'(i / 3), 4'h8 + 4'(2 * (i % 3) + h), 2'b00};
  endfunction
  function automatic logic [31:0] want(int i, int h);
    if (!seen[i])
      return 32'h0;
    return h ? {24'h0, 1'b1, old[i][14:8]} : {24'h0, old[i][7:0]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one access; waits for waitrequest low, bounded
  task automatic bus(input logic w, input logic [8:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    // request stands until waitrequest is seen low at a rising edge
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      chk(32'h1, 32'h0);
      tally_and_finish;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  // write every result byte at random, read back unchanged
  task automatic sweep;
    for (int i = 0; i < 12; i++)
      for (int h = 0; h < 2; h++)
      begin
        seed = lfsr(seed);
        be <= seed[7:4];
        bus(1'b1, ra(i, h), seed, r);
        bus(1'b0, ra(i, h), 32'h0, r);
        chk(r, want(i, h));
      end
    bus(1'b1, 9'h08C, seed, r);
    bus(1'b0, 9'h08C, 32'h0, r);
    chk(r, 32'h0);
  endtask
  task automatic meas(input int i, input logic [14:0] d);
    int n;
    seed = lfsr(seed);
    go <= 1'b1;
    port <= 2'(i / 3);
    kind <= par_kind_t'(i % 3);
    data <= d;
    dly <= 4'h5 + {1'b0, seed[2:0]};
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, ra(i, 1), 32'h0, r);
    chk(r, want(i, 1) & 32'h7F);
    n = 0;
    while (busy !== 1'b0 && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 40)
    begin
      chk(32'h1, 32'h0);
      tally_and_finish;
    end
    @(posedge clk_i);
    old[i] = d;
    seen[i] = 1'b1;
    bus(1'b0, ra(i, 0), 32'h0, r);
    chk(r, want(i, 0));
    bus(1'b0, ra(i, 1), 32'h0, r);
    chk(r, want(i, 1));
  endtask
  initial
  begin
    #2000000;
    chk(32'h1, 32'h0);
    tally_and_finish;
  end
  initial
  begin
    foreach (seen[i]) seen[i] = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    sweep();
    for (int k = 0; k < 24; k++)
      meas(k % 12, k == 5 ? 15'h7FFF : (k == 17 ? 15'h0 : seed[14:0]));
    chk({31'h0, irq}, 32'h0);
    sweep();
    bus(1'b0, 9'h100, 32'h0, r);
    chk(r, 32'h0000_0FFF);
    be <= 4'hF;
    bus(1'b1, 9'h104, 32'h0000_0FFF, r);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk_i);
    bus(1'b1, 9'h100, 32'h0000_0FFF, r);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_i);
    meas(4, 15'h1234);
    chk({31'h0, irq}, 32'h1);
    // kind code 3 names no quantity: flags and results stay put
    kind <= par_kind_t'(2'h3);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (20) @(posedge clk_i);
    bus(1'b0, 9'h100, 32'h0, r);
    chk(r, 32'h0000_0010);
    bus(1'b0, ra(4, 1), 32'h0, r);
    chk(r, want(4, 1));
    tally_and_finish;
  end
endmodule // par_top_tb_top
bind par_top par_props par_props_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .adc_evt_i(adc_evt_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .irq_o(irq_o));

//--- rtl/par_irq.sv
// sticky event status, mask and one level interrupt
// assumes clear and mask writes arrive as one-cycle strobes
`timescale 1ns/1ps
module par_irq
  import par_pkg::*;
#(
  parameter int N = 12
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // events, one-cycle pulses
  input wire logic [N-1:0] evt_i,
  // software side
  input wire logic clr_en_i,
  input wire logic [N-1:0] clr_i,
  input wire logic msk_en_i,
  input wire logic [N-1:0] msk_i,
  // state and interrupt
  output logic [N-1:0] sts_o,
  output logic [N-1:0] msk_o,
  output logic irq_o
);

  logic [N-1:0] sts_q;
  logic [N-1:0] sts_d;
  logic [N-1:0] msk_q;
  logic [N-1:0] msk_d;
  logic irq_q;
  logic irq_d;

  // a set in the clearing cycle wins, so no event is lost
  always_comb
  begin
    sts_d = sts_q;
    if (clr_en_i)
    begin
      sts_d = sts_d & ~clr_i;
    end
    sts_d = sts_d | evt_i;
    msk_d = msk_en_i ? msk_i : msk_q;
    irq_d = |(sts_d & msk_d);
  end

  // registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sts_q <= '0;
      msk_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      sts_q <= sts_d;
      msk_q <= msk_d;
      irq_q <= irq_d;
    end
  end

  assign sts_o = sts_q;
  assign msk_o = msk_q;
  assign irq_o = irq_q;

endmodule // par_irq

//--- rtl/par_pkg.sv
// constants, field layouts and carrier types of the port result bank
// assumes one clock domain and a converter sequencer on the same clock
//
// Function
// - voltage start clears the voltage done flag
// - voltage end sets the voltage done flag
// - current start clears the current done flag
// - current end sets the current done flag
// - code 1001: done plus voltage bits 14..8
// - code 1010: current result bits 7..0
// - code 1011: done plus current bits 14..8
// - code 1100: temperature bits 7..0, reset zero
// - result bytes are read only, writes ignored
// - code 1000: voltage result bits 7..0
// - code 1101: done plus temperature bits 14..8
package par_pkg;

  // converter result width and port count
  localparam int RES_W = 15;
  localparam int MAX_PORTS = 4;
  localparam int PORT_W = 2;
  localparam int KINDS = 3;

  // register select codes within one port
  localparam logic [3:0] SEL_VOLT_LO = 4'h8;
  localparam logic [3:0] SEL_VOLT_HI = 4'h9;
  localparam logic [3:0] SEL_CURR_LO = 4'hA;
  localparam logic [3:0] SEL_CURR_HI = 4'hB;
  localparam logic [3:0] SEL_TEMP_LO = 4'hC;
  localparam logic [3:0] SEL_TEMP_HI = 4'hD;

  // bus address layout: byte address is four times the index
  localparam int ADDR_W = 9;
  localparam int IDX_LSB = 2;
  localparam int SEL_LSB = 2;
  localparam int PORT_LSB = 6;
  localparam int GLOB_BIT = 8;

  // interrupt registers, index form
  localparam logic [6:0] IDX_IRQ_STS = 7'h40;
  localparam logic [6:0] IDX_IRQ_MSK = 7'h41;

  // field positions of the upper result byte
  localparam int DONE_BIT = 7;
  localparam int HI_LSB = 8;
  localparam int HI_MSB = 14;

  // reset values
  localparam logic [7:0] RES_BYTE_RST = 8'h00;
  localparam logic DONE_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // measured quantity
  typedef enum logic [1:0] {
    KIND_VOLT,
    KIND_CURR,
    KIND_TEMP
  } par_kind_t;

  // one converter event from the sequencer
  typedef struct packed {
    logic start;
    logic finish;
    logic [PORT_W-1:0] port;
    par_kind_t kind;
    logic [RES_W-1:0] data;
  } par_adc_evt_t;

  // decoded register select
  typedef struct packed {
    logic valid;
    logic upper;
    par_kind_t kind;
  } par_sel_t;

endpackage

//--- rtl/par_result_mem.sv
// result store: one word per port and quantity, registered read
// assumes writes and reads come from logic on the same clock
`timescale 1ns/1ps
module par_result_mem
  import par_pkg::*;
#(
  parameter int DW = 15,
  parameter int DEPTH = 16,
  parameter int AW = 4
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // write side
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  // read side
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);

  // storage has no reset; written flags stand in for it
  logic [DW-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] written_q;
  logic [DEPTH-1:0] written_d;
  logic [DW-1:0] rd_q;
  logic [DW-1:0] rd_d;

  generate
    if (DEPTH > (1 << AW))
    begin : g_chk
      $error("par_result_mem: depth exceeds address range");
    end
  endgenerate

  // unwritten words read as zero, so reset shows zero
  always_comb
  begin
    written_d = written_q;
    if (wr_en_i)
    begin
      written_d[wr_addr_i] = 1'b1;
    end
    if (written_q[rd_addr_i])
    begin
      rd_d = mem_q[rd_addr_i];
    end
    else
    begin
      rd_d = '0;
    end
  end

  // flags and read data
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      written_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      written_q <= written_d;
      rd_q <= rd_d;
    end
  end

  // array write, whole word at once
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = rd_q;

endmodule // par_result_mem

//--- rtl/par_top.sv
// per-port converter result registers behind an avalon-mm slave
// assumes the converter sequencer shares clk_i and sends events
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module par_top
  import par_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // converter events, same clock domain
  input wire par_adc_evt_t adc_evt_i,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // interrupt
  output logic irq_o
);

  localparam int NF = NUM_PORTS * KINDS;
  localparam int MAW = PORT_W + 2;
  localparam int DEPTH = NUM_PORTS * 4;

  generate
    if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS)
    begin : g_chk
      $error("par_top: NUM_PORTS out of range");
    end
  endgenerate

  // select code to quantity and byte half
  function automatic par_sel_t dec_sel(input logic [3:0] sel);
    par_sel_t r;
    r.valid = 1'b1;
    r.upper = 1'b0;
    r.kind = KIND_VOLT;
    case (sel)
      SEL_VOLT_LO: r.kind = KIND_VOLT;
      SEL_VOLT_HI:
      begin
        r.kind = KIND_VOLT;
        r.upper = 1'b1;
      end
      SEL_CURR_LO: r.kind = KIND_CURR;
      SEL_CURR_HI:
      begin
        r.kind = KIND_CURR;
        r.upper = 1'b1;
      end
      SEL_TEMP_LO: r.kind = KIND_TEMP;
      SEL_TEMP_HI:
      begin
        r.kind = KIND_TEMP;
        r.upper = 1'b1;
      end
      default: r.valid = 1'b0;
    endcase
    return r;
  endfunction

  // flag index of a port and quantity
  function automatic int flag_idx(input int p, input int k);
    return p * KINDS + k;
  endfunction

  // bus fields
  logic [6:0] idx;
  logic [PORT_W-1:0] bus_port;
  logic [3:0] bus_sel;
  par_sel_t bus_dec;
  logic port_ok;

  assign idx = avs_address_i[ADDR_W-1:IDX_LSB];
  assign bus_port = avs_address_i[PORT_LSB+PORT_W-1:PORT_LSB];
  assign bus_sel = avs_address_i[SEL_LSB+3:SEL_LSB];
  assign bus_dec = dec_sel(bus_sel);
  assign port_ok = ({1'b0, bus_port} < 3'(NUM_PORTS));

  // converter event qualification
  logic evt_port_ok;
  logic evt_kind_ok;
  logic evt_start;
  logic evt_finish;

  assign evt_port_ok = ({1'b0, adc_evt_i.port} < 3'(NUM_PORTS));
  assign evt_kind_ok = (adc_evt_i.kind != 2'h3);
  assign evt_start = adc_evt_i.start & evt_port_ok & evt_kind_ok;
  assign evt_finish = adc_evt_i.finish & evt_port_ok & evt_kind_ok;

  // done flags, one per port and quantity
  logic [NF-1:0] done_q;
  // nets, so each port block drives only its own slice
  wire logic [NF-1:0] done_d;
  wire logic [NF-1:0] done_evt;

  // per-port flag next state
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_port
      logic [KINDS-1:0] nxt; // next flags of this port
      logic [KINDS-1:0] fin; // finish strobes of this port
      always_comb
      begin
        for (int k = 0; k < KINDS; k++)
        begin
          nxt[k] = done_q[flag_idx(gp, k)];
          fin[k] = 1'b0;
          // measurement begins: flag drops
          if (evt_start && adc_evt_i.port == gp &&
              adc_evt_i.kind == par_kind_t'(k))
          begin
            nxt[k] = 1'b0;
          end
          // measurement ends: flag rises, end wins a tie
          if (evt_finish && adc_evt_i.port == gp &&
              adc_evt_i.kind == par_kind_t'(k))
          begin
            nxt[k] = 1'b1;
            fin[k] = 1'b1;
          end
        end
      end
      assign done_d[gp*KINDS +: KINDS] = nxt;
      assign done_evt[gp*KINDS +: KINDS] = fin;
    end
  endgenerate

  // flag registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      done_q <= {NF{DONE_RST}};
    end
    else
    begin
      done_q <= done_d;
    end
  end

  // result store: whole 15-bit word written in one cycle,
  // so a stored word never mixes two conversions; separate lower and upper byte reads can
  logic mem_we;
  logic [MAW-1:0] mem_waddr;
  logic [MAW-1:0] mem_raddr;
  logic [RES_W-1:0] mem_rdata;

  assign mem_we = evt_finish;
  assign mem_waddr = {adc_evt_i.port, adc_evt_i.kind};
  assign mem_raddr = {bus_port, bus_dec.kind};

  par_result_mem #(
    .DW(RES_W),
    .DEPTH(DEPTH),
    .AW(MAW)
  ) u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_waddr),
    .wr_data_i(adc_evt_i.data),
    .rd_addr_i(mem_raddr),
    .rd_data_o(mem_rdata)
  );

  // bus handshake: idle, fetch from store, answer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_ANS
  } par_bus_st_t;

  par_bus_st_t st_q;
  par_bus_st_t st_d;
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic req;

  // interrupt register strobes
  logic sts_clr_en;
  logic msk_wr_en;
  logic [NF-1:0] wr_bits;
  logic [NF-1:0] irq_sts;
  logic [NF-1:0] irq_msk;
  logic [31:0] be_mask;

  assign req = avs_read_i | avs_write_i;

  // byte lanes widened to a bit mask
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      be_mask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
    end
  end

  // writes land only at the accepting edge
  always_comb
  begin
    sts_clr_en = 1'b0;
    msk_wr_en = 1'b0;
    // lanes off keep the old mask bits
    wr_bits = NF'(avs_writedata_i & be_mask);
    if (st_q == ST_ANS && avs_write_i)
    begin
      // result registers take no write at all
      case (idx)
        IDX_IRQ_STS: sts_clr_en = 1'b1;
        IDX_IRQ_MSK: msk_wr_en = 1'b1;
        default: sts_clr_en = 1'b0;
      endcase
    end
  end

  par_irq #(
    .N(NF)
  ) u_irq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .evt_i(done_evt),
    .clr_en_i(sts_clr_en),
    .clr_i(wr_bits),
    .msk_en_i(msk_wr_en),
    .msk_i((wr_bits) | (irq_msk & ~NF'(be_mask))),
    .sts_o(irq_sts),
    .msk_o(irq_msk),
    .irq_o(irq_o)
  );

  // read mux and handshake next state
  always_comb
  begin
    st_d = st_q;
    wait_d = wait_q;
    rdata_d = rdata_q;
    case (st_q)
      ST_IDLE:
      begin
        // store read address sampled at this edge
        if (req)
        begin
          st_d = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        rdata_d = RDATA_RST;
        if (avs_address_i[GLOB_BIT])
        begin
          if (idx == IDX_IRQ_STS)
          begin
            rdata_d = 32'(irq_sts);
          end
          else if (idx == IDX_IRQ_MSK)
          begin
            rdata_d = 32'(irq_msk);
          end
        end
        else if (bus_dec.valid && port_ok)
        begin
          if (bus_dec.upper)
          begin
            // done flag above result bits 14..8
            rdata_d[DONE_BIT] =
              done_q[flag_idx(int'(bus_port), int'(bus_dec.kind))];
            rdata_d[DONE_BIT-1:0] = mem_rdata[HI_MSB:HI_LSB];
          end
          else
          begin
            rdata_d[7:0] = mem_rdata[7:0];
          end
        end
        // unmapped addresses answer zero
        wait_d = 1'b0;
        st_d = ST_ANS;
      end
      ST_ANS:
      begin
        // master takes the answer at this edge
        wait_d = 1'b1;
        st_d = ST_IDLE;
      end
      default:
      begin
        wait_d = 1'b1;
        st_d = ST_IDLE;
      end
    endcase
  end

  // handshake registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= ST_IDLE;
      wait_q <= 1'b1;
      rdata_q <= RDATA_RST;
    end
    else
    begin
      st_q <= st_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;

endmodule // par_top
